// File: rtl/vcc_regs.vh
// constants for the video capture port with inline colour conversion
`ifndef VCC_REGS_VH
`define VCC_REGS_VH

// port control word fields
`define VCC_CTRL_ENABLE 0
`define VCC_CTRL_RESET 23

// conversion modes
`define VCC_MODE_BYPASS 2'h0
`define VCC_MODE_RGB2YUV 2'h1
`define VCC_MODE_YUV2RGB 2'h2

// least pixels per line at each resampler input
`define VCC_MIN_UPSAMPLE 4'h4
`define VCC_MIN_DOWNSAMPLE 4'h9

// buffering: 4K bytes as 1024 words of 4 bytes, then a 4-word output fifo
`define VCC_BUF_BYTES 4096
`define VCC_WORD_BYTES 4
`define VCC_OUT_DEPTH 4

// buffered word layout
`define VCC_W_EOL 24
`define VCC_W_SOL 25
`define VCC_W_EOF 26
`define VCC_W_SOF 27
`define VCC_W_MODE_LO 28
`define VCC_W_MODE_HI 29
`define VCC_W_GUARD 30

`endif

// File: rtl/vcc_capture.v
// capture port: buffering, line guard, colour conversion and dma/descriptor output
`timescale 1ns/10ps
`include "vcc_regs.vh"

module vcc_fifo #(
	parameter W = 32,
	parameter D = 4
) (
	input wire clk, // system clock
	input wire reset, // sync reset, active high
	input wire clear, // sync flush
	input wire in_valid, // write request
	output wire in_ready, // room available
	input wire [W-1:0] in_data, // write data
	output wire out_valid, // data available
	input wire out_ready, // read accept
	output wire [W-1:0] out_data // head word
);
	localparam AW = (D > 1) ? $clog2(D) : 1;
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_ptr;
	reg [AW-1:0] rd_ptr;
	reg [AW:0] count;
	wire push;
	wire pop;

	// honest full and empty from the occupancy count
	assign in_ready = (count != D[AW:0]);
	assign out_valid = (count != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// storage array, written only on push
	always @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers wrap at the depth, which need not be a power of two
	always @(posedge clk)
	begin
		if (reset | clear)
		begin
			wr_ptr <= {AW{1'b0}};
			rd_ptr <= {AW{1'b0}};
			count <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
			count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		end
	end
endmodule

module vcc_capture (
	input wire clk, // system clock, 10 MHz
	input wire reset, // sync reset, active high
	input wire [31:0] port_ctrl, // port control word
	input wire [1:0] conv_mode, // colour conversion select
	input wire multi_channel, // multi-channel capture mode
	input wire frame_tiled, // frame data goes to tiled space
	input wire [31:0] frame_base, // frame start address
	input wire pix_valid, // pixel strobe from decoder
	input wire [23:0] pix_data, // pixel value
	input wire pix_sof, // first pixel of frame
	input wire pix_eof, // last pixel of frame
	input wire pix_sol, // first pixel of line
	input wire pix_eol, // last pixel of line
	input wire abort_req, // abort descriptor posted
	input wire overflow_clr, // clear sticky overflow
	input wire short_clr, // clear sticky short-line flag
	output reg abort_done, // list completion pulse
	output wire overflow_pulse, // parser overflow event
	output reg overflow_flag, // sticky overflow status
	output reg short_flag, // sticky short-line status
	output reg frame_busy, // frame capture in progress
	output wire dma_valid, // dma word valid
	input wire dma_ready, // dma accepts word
	output wire [23:0] dma_data, // converted pixel
	output wire [3:0] dma_marks, // sof, eof, sol, eol
	output wire [31:0] dma_addr, // word address
	output wire dma_tiled, // word targets tiled space
	output reg desc_valid, // descriptor write request
	input wire desc_ready, // descriptor accepted
	output reg [31:0] desc_addr, // descriptor address
	output reg desc_tiled, // descriptor targets tiled space
	output reg [15:0] desc_width, // pixels in last line
	output reg [15:0] desc_height // lines in frame
);
	localparam ST_RUN = 1'b0;
	localparam ST_PAD = 1'b1;
	localparam BUF_DEPTH = `VCC_BUF_BYTES / `VCC_WORD_BYTES;

	wire port_rst;
	wire flush;
	wire port_en;
	reg cap_on;
	reg [1:0] mode_q;
	reg guard_q;
	wire cap_go;
	wire [1:0] mode_now;
	wire guard_now;
	wire b_in_ready;
	wire b_valid;
	wire b_ready;
	wire [31:0] b_data;
	reg st;
	reg [23:0] pad_pix;
	reg pad_eof;
	reg [1:0] pad_mode;
	reg pad_guard;
	reg [3:0] pix_cnt;
	reg par;
	reg [7:0] hold_c;
	reg [23:0] cur_pix;
	reg [1:0] cur_mode;
	reg cur_guard;
	reg cur_sol;
	reg cur_sof;
	reg cur_eol_in;
	reg cur_eof_in;
	reg [3:0] idx;
	reg cur_par;
	reg [3:0] min_len;
	reg short_end;
	reg pad_start;
	reg eol_out;
	reg eof_out;
	reg [23:0] yuv;
	reg [23:0] conv_pix;
	reg [7:0] next_hold;
	wire pump_valid;
	wire f_in_ready;
	wire pump_push;
	wire f_out_valid;
	wire [27:0] f_out_data;
	wire dma_pop;
	reg [31:0] base_q;
	reg tiled_q;
	reg [29:0] widx;
	reg [15:0] line_px;
	reg [15:0] lines;

	// rgb to yuv 4:4:4, fixed-point bt.601 studio range
	function [23:0] rgb_to_yuv;
		input [23:0] p;
		reg signed [19:0] r;
		reg signed [19:0] g;
		reg signed [19:0] b;
		reg signed [19:0] y;
		reg signed [19:0] u;
		reg signed [19:0] v;
		begin
			r = {12'h000, p[23:16]};
			g = {12'h000, p[15:8]};
			b = {12'h000, p[7:0]};
			y = ((20'sd66 * r + 20'sd129 * g + 20'sd25 * b + 20'sd128) >>> 8) + 20'sd16;
			u = ((20'sd112 * b - 20'sd38 * r - 20'sd74 * g + 20'sd128) >>> 8) + 20'sd128;
			v = ((20'sd112 * r - 20'sd94 * g - 20'sd18 * b + 20'sd128) >>> 8) + 20'sd128;
			rgb_to_yuv = {y[7:0], u[7:0], v[7:0]};
		end
	endfunction

	// saturate to an 8-bit channel
	function [7:0] clamp8;
		input signed [19:0] x;
		begin
			if (x < 20'sd0)
				clamp8 = 8'h00;
			else if (x > 20'sd255)
				clamp8 = 8'hFF;
			else
				clamp8 = x[7:0];
		end
	endfunction

	// yuv 4:4:4 to rgb; 19 signed bits needed since the blue term passes 2^17
	function [23:0] yuv_to_rgb;
		input [23:0] p;
		reg signed [19:0] c;
		reg signed [19:0] d;
		reg signed [19:0] e;
		begin
			c = {12'h000, p[23:16]} - 20'sd16;
			d = {12'h000, p[15:8]} - 20'sd128;
			e = {12'h000, p[7:0]} - 20'sd128;
			yuv_to_rgb = {clamp8((20'sd298 * c + 20'sd409 * e + 20'sd128) >>> 8),
				clamp8((20'sd298 * c - 20'sd100 * d - 20'sd208 * e + 20'sd128) >>> 8),
				clamp8((20'sd298 * c + 20'sd516 * d + 20'sd128) >>> 8)};
		end
	endfunction

	// port reset is the global reset or the control bit; abort also flushes
	assign port_rst = reset | port_ctrl[`VCC_CTRL_RESET];
	assign flush = port_rst | abort_req;
	assign port_en = port_ctrl[`VCC_CTRL_ENABLE];

	// front end: a frame is only started while enabled, and always finished unless a port reset cuts it off
	assign cap_go = pix_valid & (cap_on | (pix_sof & port_en)) & ~port_rst;
	assign mode_now = pix_sof ? conv_mode : mode_q;
	assign guard_now = pix_sof ? ~multi_channel : guard_q;
	// the source cannot be stalled, so a full buffer drops the pixel
	assign overflow_pulse = cap_go & ~b_in_ready;

	always @(posedge clk)
	begin
		if (port_rst)
		begin
			cap_on <= 1'b0;
			frame_busy <= 1'b0;
			mode_q <= `VCC_MODE_BYPASS;
			guard_q <= 1'b0;
		end
		else
		begin
			if (pix_valid & pix_sof & port_en)
			begin
				cap_on <= 1'b1;
				mode_q <= conv_mode;
				guard_q <= ~multi_channel;
			end
			else if ((cap_go & pix_eof) | ~frame_busy)
				cap_on <= port_en; // disable takes hold at frame end
			if (cap_go)
				frame_busy <= ~pix_eof;
		end
	end

	// sticky overflow; a new event beats a clear in the same cycle
	always @(posedge clk)
	begin
		if (reset)
			overflow_flag <= 1'b0;
		else if (overflow_pulse)
			overflow_flag <= 1'b1;
		else if (overflow_clr)
			overflow_flag <= 1'b0;
	end

	// 4K-byte capture buffer, one pixel per 4-byte word
	vcc_fifo #(.W(32), .D(BUF_DEPTH)) u_buf (
		.clk(clk),
		.reset(reset),
		.clear(flush),
		.in_valid(cap_go),
		.in_ready(b_in_ready),
		.in_data({1'b0, guard_now, mode_now, pix_sof, pix_eof, pix_sol, pix_eol, pix_data}),
		.out_valid(b_valid),
		.out_ready(b_ready),
		.out_data(b_data)
	);

	// line guard: in single-channel resampling modes, short lines are padded with the last pixel; other lines pass as they are
	always @*
	begin
		cur_pix = (st == ST_PAD) ? pad_pix : b_data[23:0];
		cur_mode = (st == ST_PAD) ? pad_mode : b_data[`VCC_W_MODE_HI:`VCC_W_MODE_LO];
		cur_guard = (st == ST_PAD) ? pad_guard : b_data[`VCC_W_GUARD];
		cur_sol = (st == ST_RUN) & b_data[`VCC_W_SOL];
		cur_sof = (st == ST_RUN) & b_data[`VCC_W_SOF];
		cur_eol_in = (st == ST_RUN) & b_data[`VCC_W_EOL];
		cur_eof_in = (st == ST_PAD) ? pad_eof : b_data[`VCC_W_EOF];
		idx = cur_sol ? 4'h0 : pix_cnt;
		cur_par = cur_sol ? 1'b0 : par;
		if (cur_mode == `VCC_MODE_RGB2YUV)
			min_len = `VCC_MIN_DOWNSAMPLE;
		else
			min_len = `VCC_MIN_UPSAMPLE;
		// only overflow-truncated lines can be short in practice
		// mode 3 converts nothing, so only the two resampling modes are guarded; 5 bits keep a saturated count long
		short_end = cur_guard & ((cur_mode == `VCC_MODE_RGB2YUV) | (cur_mode == `VCC_MODE_YUV2RGB))
			& (({1'b0, idx} + 5'h01) < {1'b0, min_len});
		pad_start = cur_eol_in & short_end;
		if (st == ST_PAD)
			eol_out = ~short_end;
		else
			eol_out = cur_eol_in & ~pad_start;
		eof_out = eol_out & cur_eof_in;
		// conversion path with a one-register chroma hold per pixel pair
		yuv = rgb_to_yuv(cur_pix);
		conv_pix = cur_pix;
		next_hold = hold_c;
		if (cur_mode == `VCC_MODE_RGB2YUV)
		begin
			// even pixel carries its own cb, odd pixel the held cr of the pair
			conv_pix = {8'h00, yuv[23:16], cur_par ? hold_c : yuv[15:8]};
			next_hold = yuv[7:0];
		end
		else if (cur_mode == `VCC_MODE_YUV2RGB)
		begin
			// even word is y/cb, odd word is y/cr; the partner comes from the hold
			if (cur_par)
				conv_pix = yuv_to_rgb({cur_pix[15:8], hold_c, cur_pix[7:0]});
			else
				conv_pix = yuv_to_rgb({cur_pix[15:8], cur_pix[7:0], hold_c});
			next_hold = cur_pix[7:0];
		end
	end

	assign pump_valid = (st == ST_PAD) | b_valid;
	assign pump_push = pump_valid & f_in_ready;
	// back-pressure from the output fifo stalls the buffer drain
	assign b_ready = (st == ST_RUN) & f_in_ready;

	// guard and resampler state
	always @(posedge clk)
	begin
		if (flush)
		begin
			st <= ST_RUN;
			pix_cnt <= 4'h0;
			par <= 1'b0;
			hold_c <= 8'h80;
			pad_pix <= 24'h000000;
			pad_eof <= 1'b0;
			pad_mode <= `VCC_MODE_BYPASS;
			pad_guard <= 1'b0;
		end
		else if (pump_push)
		begin
			pix_cnt <= eol_out ? 4'h0 : ((idx == 4'hF) ? 4'hF : idx + 4'h1);
			par <= eol_out ? 1'b0 : ~cur_par;
			hold_c <= next_hold;
			if (st == ST_RUN)
			begin
				pad_pix <= b_data[23:0];
				pad_eof <= b_data[`VCC_W_EOF];
				pad_mode <= b_data[`VCC_W_MODE_HI:`VCC_W_MODE_LO];
				pad_guard <= b_data[`VCC_W_GUARD];
			end
			if (pad_start)
				st <= ST_PAD;
			else if (eol_out)
				st <= ST_RUN;
		end
	end

	// sticky short-line flag, set wins over clear
	always @(posedge clk)
	begin
		if (reset)
			short_flag <= 1'b0;
		else if (pump_push & pad_start)
			short_flag <= 1'b1;
		else if (short_clr)
			short_flag <= 1'b0;
	end

	// small output fifo toward the video_dma
	vcc_fifo #(.W(28), .D(`VCC_OUT_DEPTH)) u_out (
		.clk(clk),
		.reset(reset),
		.clear(flush),
		.in_valid(pump_valid),
		.in_ready(f_in_ready),
		.in_data({cur_sof, eof_out, cur_sol, eol_out, conv_pix}),
		.out_valid(f_out_valid),
		.out_ready(dma_pop),
		.out_data(f_out_data)
	);

	// words wait while a descriptor is pending so it follows its frame
	assign dma_valid = f_out_valid & ~desc_valid;
	assign dma_pop = dma_valid & dma_ready;
	assign dma_data = f_out_data[23:0];
	assign dma_marks = f_out_data[27:24];
	assign dma_addr = f_out_data[27] ? frame_base : base_q + {widx, 2'b00};
	assign dma_tiled = f_out_data[27] ? frame_tiled : tiled_q;

	// address walk and frame geometry for the descriptor
	always @(posedge clk)
	begin
		if (flush)
		begin
			base_q <= 32'h00000000;
			tiled_q <= 1'b0;
			widx <= 30'h00000000;
			line_px <= 16'h0000;
			lines <= 16'h0000;
			desc_valid <= 1'b0;
			desc_addr <= 32'h00000000;
			desc_tiled <= 1'b0;
			desc_width <= 16'h0000;
			desc_height <= 16'h0000;
		end
		else
		begin
			if (desc_valid & desc_ready)
				desc_valid <= 1'b0;
			if (dma_pop)
			begin
				if (f_out_data[27])
				begin
					base_q <= frame_base;
					tiled_q <= frame_tiled;
					widx <= 30'h00000001;
					lines <= 16'h0000;
				end
				else
					widx <= widx + 30'h00000001;
				line_px <= f_out_data[24] ? 16'h0000 : line_px + 16'h0001;
				if (f_out_data[24])
					lines <= (f_out_data[27] ? 16'h0000 : lines) + 16'h0001;
				if (f_out_data[26])
				begin
					desc_valid <= 1'b1;
					// first word past the last pixel, so no pixel is overwritten
					desc_addr <= (f_out_data[27] ? frame_base : base_q)
						+ {(f_out_data[27] ? 30'h00000001 : widx + 30'h00000001), 2'b00};
					desc_tiled <= f_out_data[27] ? frame_tiled : tiled_q;
					desc_width <= line_px + 16'h0001;
					desc_height <= (f_out_data[27] ? 16'h0000 : lines) + {15'h0000, f_out_data[24]};
				end
			end
		end
	end

	// abort completion one cycle after the abort is posted
	always @(posedge clk)
	begin
		if (reset)
			abort_done <= 1'b0;
		else
			abort_done <= abort_req;
	end
endmodule

// File: verif/vcc_capture_checker.sv
// concurrent checks on the capture port outputs
`timescale 1ns/10ps
module vcc_capture_checker (
	input logic clk, // clock
	input logic reset, // sync reset
	input logic [31:0] port_ctrl, // control word
	input logic abort_req, // abort posted
	input logic overflow_clr, // flag clear
	input logic pix_valid, // pixel strobe
	input logic frame_tiled, // tiled frame
	input logic [31:0] frame_base, // frame base
	input logic abort_done, // abort answer
	input logic overflow_pulse, // overflow event
	input logic overflow_flag, // sticky overflow
	input logic frame_busy, // frame open
	input logic dma_valid, // word valid
	input logic dma_ready, // word taken
	input logic [3:0] dma_marks, // frame marks
	input logic [31:0] dma_addr, // word address
	input logic dma_tiled, // word tiled
	input logic desc_valid, // descriptor valid
	input logic desc_ready, // descriptor taken
	input logic [31:0] desc_addr, // descriptor address
	input logic desc_tiled // descriptor tiled
);
	logic [31:0] h_base;
	logic h_tiled;
	logic [15:0] h_cnt;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// follow each frame as the dma takes it, to predict its descriptor
	always @(posedge clk)
	begin
		if (dma_valid && dma_ready)
		begin
			h_base <= dma_marks[3] ? dma_addr : h_base;
			h_tiled <= dma_marks[3] ? dma_tiled : h_tiled;
			h_cnt <= dma_marks[3] ? 16'h1 : h_cnt + 16'h1;
		end
	end
	sequence s_eof_pop;
		dma_valid && dma_ready && dma_marks[2];
	endsequence
	// a flush by abort or port reset may drop a waiting descriptor
	sequence s_desc_wait;
		desc_valid && !desc_ready && !abort_req && !port_ctrl[23];
	endsequence
	AST_DESC_AFTER_EOF: assert property (s_eof_pop |=> desc_valid) else $error("no descriptor after eof");
	AST_DESC_HOLD: assert property (s_desc_wait |=> desc_valid && $stable(desc_addr)) else $error("descriptor moved");
	AST_DESC_ADDR:
		assert property (desc_valid |-> desc_addr == h_base + 32'(h_cnt) * 4) else $error("descriptor overlaps pixels");
	AST_DESC_TILED: assert property (desc_valid |-> desc_tiled == h_tiled) else $error("descriptor space wrong");
	AST_SOF_WORD:
		assert property (dma_valid && dma_marks[3] |-> dma_addr == frame_base && dma_tiled == frame_tiled)
		else $error("first word placement wrong");
	AST_DESC_NO_DMA: assert property (desc_valid |-> !dma_valid) else $error("word during descriptor");
	AST_PORT_RESET: assert property (port_ctrl[23] |=> !dma_valid && !frame_busy) else $error("port not held");
	AST_ABORT: assert property (abort_req |=> abort_done && !desc_valid) else $error("abort not answered");
	AST_OVF_SET: assert property (overflow_pulse |-> pix_valid ##1 overflow_flag) else $error("overflow not held");
	AST_OVF_HOLD: assert property (overflow_flag && !overflow_clr |=> overflow_flag) else $error("overflow lost");
	AST_OVF_CLR:
		assert property (overflow_clr && !overflow_pulse |=> !overflow_flag) else $error("overflow not cleared");
endmodule

// File: verif/vcc_dma_sink.sv
// memory-side model: takes dma words and descriptors, promptly or slowly
`timescale 1ns/10ps
module vcc_dma_sink (
	input logic clk, // clock
	input logic reset, // sync reset
	input logic slow, // ready every other cycle
	input logic hold, // never ready
	input logic dma_valid, // word valid
	input logic [3:0] dma_marks, // frame marks
	input logic [31:0] dma_addr, // word address
	output logic dma_ready, // word taken
	input logic desc_valid, // descriptor valid
	output logic desc_ready, // descriptor taken
	output logic [15:0] n_words, // words of frame
	output logic addr_err // address step broken
);
	logic phase;
	logic [1:0] dly;
	logic [31:0] last;
	// descriptor answered late so the design must wait with its fields held
	always @(posedge clk)
	begin
		if (reset)
		begin
			phase <= 1'h0;
			dma_ready <= 1'h0;
			desc_ready <= 1'h0;
			dly <= 2'h0;
			n_words <= 16'h0;
			addr_err <= 1'h0;
		end
		else
		begin
			phase <= ~phase;
			dma_ready <= !hold && (!slow || phase);
			desc_ready <= 1'h0;
			if (desc_valid && !desc_ready)
				dly <= dly + 2'h1;
			if (desc_valid && !desc_ready && dly == 2'h2)
			begin
				desc_ready <= 1'h1;
				dly <= 2'h0;
			end
			if (dma_valid && dma_ready)
			begin
				last <= dma_addr;
				n_words <= dma_marks[3] ? 16'h1 : n_words + 16'h1;
				if (!dma_marks[3] && dma_addr !== last + 32'h4)
					addr_err <= 1'h1;
			end
		end
	end
endmodule

// File: verif/testbench.sv
// testbench for the capture port: row table, then overflow, recovery and reset
`timescale 1ns/10ps
module testbench;
	typedef struct packed {logic [1:0] mode; logic multi; logic [7:0] len; logic tiled; logic [7:0] words; logic shrt;} vcc_row_t;
	// mode, multi, pixels sent, tiled, words expected, padded
	vcc_row_t rows [7] = '{'{2'h0, 1'h0, 8'h03, 1'h0, 8'h03, 1'h0}, '{2'h1, 1'h0, 8'h03, 1'h1, 8'h09, 1'h1},
		'{2'h1, 1'h0, 8'h09, 1'h0, 8'h09, 1'h0}, '{2'h2, 1'h0, 8'h02, 1'h1, 8'h04, 1'h1},
		'{2'h1, 1'h1, 8'h03, 1'h1, 8'h03, 1'h0}, '{2'h3, 1'h0, 8'h02, 1'h0, 8'h02, 1'h0},
		'{2'h2, 1'h0, 8'h04, 1'h0, 8'h04, 1'h0}};
	logic clk, reset, multi_channel, frame_tiled, pix_valid, pix_sof, pix_eof, pix_sol, pix_eol;
	logic abort_req, overflow_clr, short_clr, abort_done, overflow_pulse, overflow_flag, short_flag, frame_busy;
	logic dma_valid, dma_ready, dma_tiled, desc_valid, desc_ready, desc_tiled, slow, hold, addr_err;
	logic [1:0] conv_mode;
	logic [3:0] dma_marks;
	logic [23:0] pix_data, dma_data, eof_data;
	logic [3:0] eof_marks;
	logic [15:0] desc_width, desc_height, n_words;
	logic [31:0] port_ctrl, frame_base, dma_addr, desc_addr;
	int failures, n_tests, k;
	vcc_capture i_vcc_capture (.clk, .reset, .port_ctrl, .conv_mode, .multi_channel, .frame_tiled, .frame_base,
		.pix_valid, .pix_data, .pix_sof, .pix_eof, .pix_sol, .pix_eol, .abort_req, .overflow_clr, .short_clr,
		.abort_done, .overflow_pulse, .overflow_flag, .short_flag, .frame_busy, .dma_valid, .dma_ready, .dma_data,
		.dma_marks, .dma_addr, .dma_tiled, .desc_valid, .desc_ready, .desc_addr, .desc_tiled, .desc_width,
		.desc_height);
	vcc_dma_sink i_vcc_dma_sink (.clk, .reset, .slow, .hold, .dma_valid, .dma_marks, .dma_addr, .dma_ready,
		.desc_valid, .desc_ready, .n_words, .addr_err);
	always #50 clk = ~clk;
	// last word of each frame as memory takes it
	always @(posedge clk)
	begin
		if (dma_valid && dma_ready && dma_marks[2])
		begin
			eof_data <= dma_data;
			eof_marks <= dma_marks;
		end
	end
	task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task tmo;
		failures++;
		$display("mismatch wait expected done seen timeout");
		stop_test;
	endtask
	// one line of n pixels, optionally opening or closing the frame
	task send(input int n, input logic first, input logic last);
		for (int i = 0; i < n; i++)
		begin
			@(posedge clk);
			pix_valid <= 1'h1;
			pix_data <= i[23:0];
			pix_sof <= first && i == 0;
			pix_sol <= i == 0;
			pix_eol <= i == n - 1;
			pix_eof <= last && i == n - 1;
		end
		@(posedge clk);
		pix_valid <= 1'h0;
	endtask
	task run_row(input vcc_row_t r, input logic [31:0] base);
		@(posedge clk);
		conv_mode <= r.mode;
		multi_channel <= r.multi;
		frame_tiled <= r.tiled;
		frame_base <= base;
		send(r.len, 1'h1, 1'h1);
		for (k = 0; k < 300 && desc_valid !== 1'h1; k++) @(posedge clk) #1;
		if (desc_valid !== 1'h1)
			tmo;
		chk("desc_addr", desc_addr, base + 32'(r.words) * 4);
		chk("desc_tiled", desc_tiled, r.tiled);
		chk("desc_height", desc_height, 32'h1);
		chk("desc_width", desc_width, r.words);
		chk("eof_marks", eof_marks, 4'h5);
		if (r.mode == 2'h0 || r.mode == 2'h3)
			chk("eof_data", eof_data, 32'(r.len) - 32'h1);
		chk("words", n_words, r.words);
		chk("addr_step", addr_err, 1'h0);
		chk("short_flag", short_flag, r.shrt);
		@(posedge clk);
		short_clr <= 1'h1;
		@(posedge clk);
		short_clr <= 1'h0;
		for (k = 0; k < 20 && desc_valid !== 1'h0; k++) @(posedge clk) #1;
		if (desc_valid !== 1'h0)
			tmo;
	endtask
	initial
	begin
		{clk, multi_channel, frame_tiled, pix_valid, pix_sof, pix_eof, pix_sol, pix_eol} = 8'h00;
		{abort_req, overflow_clr, short_clr, slow, hold, conv_mode} = 7'h00;
		{pix_data, frame_base, port_ctrl, reset} = {56'h0, 32'h1, 1'h1};
		repeat (8) @(posedge clk);
		reset <= 1'h0;
		for (int r = 0; r < 7; r++)
		begin
			slow <= r[0];
			run_row(rows[r], 32'(r + 1) * 32'h10000);
			$display("row %0d done", r);
		end
		// memory stalled while a 1000-pixel line and then a 100-pixel line overrun the buffer
		@(posedge clk);
		{conv_mode, slow, hold} <= 4'h1;
		send(1000, 1'h1, 1'h0);
		@(posedge clk) #1;
		chk("ovf_early", overflow_flag, 1'h0);
		send(100, 1'h0, 1'h0);
		@(posedge clk) #1;
		chk("ovf_late", overflow_flag, 1'h1);
		$display("overflow done");
		// recovery: disable, end frame, port reset, abort, release, restart
		@(posedge clk);
		port_ctrl <= 32'h0;
		hold <= 1'h0;
		repeat (10) @(posedge clk);
		send(1, 1'h0, 1'h1);
		for (k = 0; k < 3000 && frame_busy !== 1'h0; k++) @(posedge clk) #1;
		if (frame_busy !== 1'h0)
			tmo;
		@(posedge clk);
		port_ctrl <= 32'h0080_0000;
		@(posedge clk);
		abort_req <= 1'h1;
		@(posedge clk);
		abort_req <= 1'h0;
		#1;
		chk("abort_done", abort_done, 1'h1);
		chk("dma_idle", dma_valid, 1'h0);
		chk("ovf_kept", overflow_flag, 1'h1);
		@(posedge clk);
		port_ctrl <= 32'h0;
		overflow_clr <= 1'h1;
		@(posedge clk);
		port_ctrl <= 32'h1;
		overflow_clr <= 1'h0;
		@(posedge clk) #1;
		chk("ovf_clr", overflow_flag, 1'h0);
		run_row(rows[2], 32'h0009_0000);
		$display("recovery done");
		// reset in mid-frame clears the open frame
		@(posedge clk);
		send(3, 1'h1, 1'h0);
		reset <= 1'h1;
		@(posedge clk);
		reset <= 1'h0;
		#1;
		chk("busy_rst", frame_busy, 1'h0);
		chk("dma_rst", dma_valid, 1'h0);
		// the port must capture cleanly after a reset in mid-frame
		run_row(rows[0], 32'h000A_0000);
		$display("reset done");
		stop_test;
	end
endmodule
bind vcc_capture vcc_capture_checker i_vcc_capture_checker (.clk, .reset, .port_ctrl, .abort_req, .overflow_clr,
	.pix_valid, .frame_tiled, .frame_base, .abort_done, .overflow_pulse, .overflow_flag, .frame_busy, .dma_valid,
	.dma_ready, .dma_marks, .dma_addr, .dma_tiled, .desc_valid, .desc_ready, .desc_addr, .desc_tiled);
